//--- design/rsq_pkg.sv
// constants shared by the internal reset sequencer
// assumes one 50 MHz clock that also stands for the oscillator clock
package rsq_pkg;
    // bus geometry
    localparam int RSQ_ADDR_W = 8;
    localparam int RSQ_DATA_W = 32;
    // register byte offsets
    localparam logic [7:0] RSQ_OFS_CAUSE = 8'h00; // reset cause flags
    localparam logic [7:0] RSQ_OFS_OPT   = 8'h04; // option bits
    localparam logic [7:0] RSQ_OFS_STAT  = 8'h08; // live state
    localparam logic [7:0] RSQ_OFS_SVC   = 8'h0c; // watchdog service
    // cause flag positions
    localparam int RSQ_F_POR  = 7;
    localparam int RSQ_F_PIN  = 6;
    localparam int RSQ_F_WDOG = 5;
    localparam int RSQ_F_OPC  = 4;
    localparam int RSQ_F_ADR  = 3;
    localparam int RSQ_F_LVD  = 1;
    localparam logic [7:0] RSQ_CAUSE_RST = 8'h80;
    // option bit positions and reset value
    localparam int RSQ_O_STOPEN = 0;
    localparam int RSQ_O_SHORT  = 1;
    localparam logic [1:0] RSQ_OPT_RST = 2'h0;
    // status field positions
    localparam int RSQ_S_STATE = 16;
    localparam int RSQ_S_WDOG  = 20;
    // timing in oscillator cycles
    localparam int RSQ_CNT_W     = 13;
    localparam int RSQ_PIN_CYC   = 32;
    localparam int RSQ_HOLD_CYC  = 32;
    localparam int RSQ_POR_CYC   = 4096;
    localparam int RSQ_SHORT_REC = 32;
    localparam int RSQ_LONG_REC  = 4096;
    localparam int RSQ_SVC_LSB   = 4;
    // axi responses
    localparam logic [1:0] RSQ_RESP_OK  = 2'h0;
    localparam logic [1:0] RSQ_RESP_ERR = 2'h2;
    typedef enum logic [2:0] {
        RSQ_RUN, RSQ_POR, RSQ_DRIVE, RSQ_HOLD, RSQ_STOP, RSQ_RECOV
    } rsq_state_e;
endpackage : rsq_pkg

//--- design/rsq_internal_reset_sequencer.sv
// internal reset sequencer: reset pin drive, internal reset, cause flags,
// stabilisation counter, stop recovery and watchdog counter
// assumes cpu-side strobes on this clock; pin-side inputs are asynchronous
`timescale 1ns/1ns
// What this block does
// - drive reset pin low 32 cycles
// - hold internal reset 32 more cycles
// - five internal causes start active sequence
// - power/low-voltage: 4096 cycles pin low first
// - watchdog request synchronised before use
// - power-on release 64 cycles after count
// - power-on: reset, clock gen on, clocks off
// - power-on sets its flag, clears others
// - watchdog overflow resets, sets its flag
// - service write clears watchdog, counter 12:4
// - counter tick clocks the watchdog counter
// - watchdog disabled only by high-voltage logic
// - bad opcode sets flag and resets
// - stop without option is bad opcode
// - unmapped opcode fetch sets flag, resets
// - unmapped data read does nothing
// - stop recovery 32 or 4096 cycles
// - pin reset leaves counter unchanged
// - counter free-runs after reset states
// - clock generator enabled after initialisation
// - internal reset clears counter, pin not
// - internal reset returns modules to defaults
module rsq_internal_reset_sequencer #(
    parameter int WD_BITS = 6             // watchdog counter width
) (
    input  wire logic                         clock,              // 50 MHz clock
    input  wire logic                         rst,                // sync reset, high
    input  wire logic                         power_on_pulse,     // async power-on
    input  wire logic                         low_voltage_detect, // async low voltage
    input  wire logic                         wdog_req_async,     // async watchdog req
    input  wire logic                         rst_pin_i,          // reset pin level
    output logic                              rst_pin_o,          // pin drive value
    output logic                              rst_pin_oe,         // pin drive enable
    input  wire logic                         hv_rst_pin,         // high volt on pin
    input  wire logic                         hv_irq_pin,         // high volt on irq
    input  wire logic                         monitor_mode,       // monitor mode
    input  wire logic                         break_state,        // break state
    input  wire logic                         bad_opcode,         // illegal decode
    input  wire logic                         stop_exec,          // stop executed
    input  wire logic                         stop_wake,          // stop exit event
    input  wire logic                         opcode_fetch,       // cycle is fetch
    input  wire logic                         fetch_unmapped,     // address unmapped
    output logic                              internal_reset,     // reset to modules
    output logic                              clock_gen_output,   // clock gen enable
    output logic                              cpu_clk_en,         // cpu/module clocks
    output logic                              wdog_disabled,      // watchdog off
    input  wire logic [rsq_pkg::RSQ_ADDR_W-1:0] s_axi_awaddr,     // write address
    input  wire logic                         s_axi_awvalid,      // aw valid
    output logic                              s_axi_awready,      // aw ready
    input  wire logic [rsq_pkg::RSQ_DATA_W-1:0] s_axi_wdata,      // write data
    input  wire logic [3:0]                   s_axi_wstrb,        // byte strobes
    input  wire logic                         s_axi_wvalid,       // w valid
    output logic                              s_axi_wready,       // w ready
    output logic [1:0]                        s_axi_bresp,        // write response
    output logic                              s_axi_bvalid,       // b valid
    input  wire logic                         s_axi_bready,       // b ready
    input  wire logic [rsq_pkg::RSQ_ADDR_W-1:0] s_axi_araddr,     // read address
    input  wire logic                         s_axi_arvalid,      // ar valid
    output logic                              s_axi_arready,      // ar ready
    output logic [rsq_pkg::RSQ_DATA_W-1:0]    s_axi_rdata,        // read data
    output logic [1:0]                        s_axi_rresp,        // read response
    output logic                              s_axi_rvalid,       // r valid
    input  wire logic                         s_axi_rready        // r ready
);
    import rsq_pkg::*;

    if (WD_BITS < 1 || WD_BITS > 8) begin : g_bad_width
        $error("WD_BITS must be 1 to 8");
    end

    localparam logic [RSQ_CNT_W-1:0] CNT_PIN  = RSQ_CNT_W'(RSQ_PIN_CYC - 1);
    localparam logic [RSQ_CNT_W-1:0] CNT_HOLD = RSQ_CNT_W'(RSQ_HOLD_CYC - 1);
    localparam logic [RSQ_CNT_W-1:0] CNT_POR  = RSQ_CNT_W'(RSQ_POR_CYC - 1);
    localparam logic [RSQ_CNT_W-1:0] CNT_SREC = RSQ_CNT_W'(RSQ_SHORT_REC - 1);
    localparam logic [RSQ_CNT_W-1:0] CNT_LREC = RSQ_CNT_W'(RSQ_LONG_REC - 1);

    logic [7:0]           sync1_reg;
    logic [7:0]           sync2_reg;
    rsq_state_e           state_reg;
    rsq_state_e           state_next;
    logic [RSQ_CNT_W-1:0] cnt_reg;
    logic [RSQ_CNT_W-1:0] cnt_next;
    logic [WD_BITS-1:0]   wd_cnt_reg;
    logic [WD_BITS-1:0]   wd_cnt_next;
    logic                 wd_ovf_reg;
    logic [7:0]           cause_reg;
    logic [7:0]           cause_next;
    logic [1:0]           opt_reg;
    logic                 aw_hold_reg;
    logic                 w_hold_reg;
    logic [7:0]           aw_addr_reg;
    logic [31:0]          w_data_reg;
    logic                 w_strb0_reg;

    // two-flop synchronisers for every pin-side input; watchdog request
    always_ff @(posedge clock) begin
        sync1_reg <= {break_state, monitor_mode, hv_irq_pin, hv_rst_pin,
                      rst_pin_i, wdog_req_async,
                      low_voltage_detect, power_on_pulse};
        sync2_reg <= sync1_reg;
    end

    // synchronised pin levels
    wire por_s   = sync2_reg[0];
    wire lvd_s   = sync2_reg[1];
    wire wdreq_s = sync2_reg[2];
    wire pin_s   = sync2_reg[3];
    wire hvrst_s = sync2_reg[4];
    wire hvirq_s = sync2_reg[5];
    wire mon_s   = sync2_reg[6];
    wire brk_s   = sync2_reg[7];

    wire wd_off = (mon_s & (hvrst_s | hvirq_s)) | (brk_s & hvrst_s);

    // cause decode while running
    wire running   = (state_reg == RSQ_RUN);
    wire por_lvd   = por_s | lvd_s;
    // stop without option is a bad opcode
    wire opc_evt   = running & (bad_opcode | (stop_exec & ~opt_reg[RSQ_O_STOPEN]));
    wire adr_evt   = running & opcode_fetch & fetch_unmapped;
    wire wd_evt    = running & (wdreq_s | wd_ovf_reg); // own overflow is already on this clock
    // any internal cause starts the sequence
    wire int_evt   = opc_evt | adr_evt | wd_evt;
    wire stop_go   = running & stop_exec & opt_reg[RSQ_O_STOPEN];
    wire pin_low   = ~pin_s & (running | state_reg == RSQ_STOP
                               | state_reg == RSQ_RECOV);
    wire por_done  = (state_reg == RSQ_POR) & (cnt_reg == CNT_POR);
    wire drv_done  = (state_reg == RSQ_DRIVE) & (cnt_reg == CNT_PIN);
    wire hold_done = (state_reg == RSQ_HOLD) & (cnt_reg == CNT_HOLD);
    // recovery length from the option bit
    wire rec_done  = (state_reg == RSQ_RECOV)
                   & (cnt_reg == (opt_reg[RSQ_O_SHORT] ? CNT_SREC : CNT_LREC));
    // tick on counter wrap, at least 2^13 cycles apart
    wire tick      = running & (cnt_reg == {RSQ_CNT_W{1'b1}});

    // bus decode
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire wr_fire = aw_hold_reg & w_hold_reg;
    wire wa_cause = (aw_addr_reg[7:2] == RSQ_OFS_CAUSE[7:2]);
    wire wa_opt   = (aw_addr_reg[7:2] == RSQ_OFS_OPT[7:2]);
    wire wa_stat  = (aw_addr_reg[7:2] == RSQ_OFS_STAT[7:2]);
    wire wa_svc   = (aw_addr_reg[7:2] == RSQ_OFS_SVC[7:2]);
    wire wa_ok    = wa_cause | wa_opt | wa_stat | wa_svc;
    // any value written to the service word
    wire svc      = wr_fire & wa_svc & running;
    wire [7:0] clr_mask = (wr_fire & wa_cause & w_strb0_reg) ? w_data_reg[7:0] : 8'h00;

    // state sequencing; power-on and low voltage restart from anywhere
    always_comb begin
        state_next = state_reg;
        // power-on and low voltage first hold the long count
        if (por_lvd) begin
            state_next = RSQ_POR;
        end else begin
            case (state_reg)
                RSQ_RUN: begin
                    if (int_evt) begin
                        state_next = RSQ_DRIVE;
                    end else if (stop_go) begin
                        state_next = RSQ_STOP;
                    end
                end
                RSQ_POR: begin
                    if (por_done) begin
                        state_next = RSQ_DRIVE;
                    end
                end
                RSQ_DRIVE: begin
                    if (drv_done) begin
                        state_next = RSQ_HOLD;
                    end
                end
                // release after pin drive plus hold
                RSQ_HOLD: begin
                    if (hold_done) begin
                        state_next = RSQ_RUN;
                    end
                end
                RSQ_STOP: begin
                    if (stop_wake | pin_low) begin
                        state_next = RSQ_RECOV;
                    end
                end
                RSQ_RECOV: begin
                    if (rec_done) begin
                        state_next = RSQ_RUN;
                    end
                end
                default: state_next = RSQ_POR;
            endcase
        end
    end

    // counter clears on internal reset phases and stop, not pin
    wire cnt_clr = por_lvd | (running & (int_evt | stop_go)) | por_done
                 | drv_done | (state_reg == RSQ_STOP);
    assign cnt_next = cnt_clr ? '0
                    : svc ? {{(RSQ_CNT_W - RSQ_SVC_LSB){1'b0}},
                             cnt_reg[RSQ_SVC_LSB-1:0] + 1'b1} // no carry into bit 4
                    : cnt_reg + 1'b1;

    wire wd_ovf = tick & ~wd_off & (&wd_cnt_reg);
    assign wd_cnt_next = (svc | ~running) ? '0
                       : (tick & ~wd_off) ? wd_cnt_reg + 1'b1
                       : wd_cnt_reg;

    // cause flag sets; power-on clears all others
    wire [7:0] set_mask = ({7'h0, lvd_s} << RSQ_F_LVD)
                        | ({7'h0, wd_evt} << RSQ_F_WDOG)
                        | ({7'h0, opc_evt} << RSQ_F_OPC)
                        | ({7'h0, adr_evt} << RSQ_F_ADR)
                        | ({7'h0, pin_low & running} << RSQ_F_PIN);
    assign cause_next = por_s ? RSQ_CAUSE_RST : ((cause_reg & ~clr_mask) | set_mask);

    // sequencer registers
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg  <= RSQ_POR;
            cnt_reg    <= '0;
            wd_cnt_reg <= '0;
            wd_ovf_reg <= 1'b0;
            cause_reg  <= RSQ_CAUSE_RST;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            wd_cnt_reg <= wd_cnt_next;
            wd_ovf_reg <= wd_ovf;
            cause_reg  <= cause_next;
        end
    end

    // next-state views of the outputs
    wire nx_drive = (state_next == RSQ_POR) | (state_next == RSQ_DRIVE);
    wire nx_internal_reset  = nx_drive | (state_next == RSQ_HOLD);

    // pin and clock outputs
    always_ff @(posedge clock) begin
        if (rst) begin
            rst_pin_o        <= 1'b0;
            rst_pin_oe       <= 1'b1;
            internal_reset   <= 1'b1;
            clock_gen_output <= 1'b0;
            cpu_clk_en       <= 1'b0;
            wdog_disabled    <= 1'b0;
        end else begin
            rst_pin_o        <= 1'b0;
            // drive the pin only during active phases
            rst_pin_oe       <= nx_drive;
            // internal reset covers drive and hold
            internal_reset   <= nx_internal_reset | pin_low;
            clock_gen_output <= clock_gen_output | (state_reg == RSQ_POR);
            cpu_clk_en       <= (state_next == RSQ_RUN) & ~pin_low;
            wdog_disabled    <= wd_off;
        end
    end

    // read data select
    wire ra_cause = (s_axi_araddr[7:2] == RSQ_OFS_CAUSE[7:2]);
    wire ra_opt   = (s_axi_araddr[7:2] == RSQ_OFS_OPT[7:2]);
    wire ra_stat  = (s_axi_araddr[7:2] == RSQ_OFS_STAT[7:2]);
    wire ra_svc   = (s_axi_araddr[7:2] == RSQ_OFS_SVC[7:2]);
    wire [31:0] stat_word = (32'(wd_cnt_reg) << RSQ_S_WDOG)
                          | (32'(state_reg) << RSQ_S_STATE) | 32'(cnt_reg);
    wire [31:0] rd_word = ra_cause ? {24'h0, cause_reg}
                        : ra_opt ? {30'h0, opt_reg}
                        : ra_stat ? stat_word
                        : 32'h0;
    wire rd_ok = ra_cause | ra_opt | ra_stat | ra_svc;

    // axi write channel
    always_ff @(posedge clock) begin
        if (rst) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0;
            w_strb0_reg   <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RSQ_RESP_OK;
            opt_reg       <= RSQ_OPT_RST;
        end else begin
            aw_hold_reg   <= (aw_hold_reg | aw_take) & ~wr_fire;
            w_hold_reg    <= (w_hold_reg | w_take) & ~wr_fire;
            s_axi_awready <= ~(aw_hold_reg | aw_take) & ~wr_fire
                           & ~(s_axi_bvalid & ~s_axi_bready);
            s_axi_wready  <= ~(w_hold_reg | w_take) & ~wr_fire
                           & ~(s_axi_bvalid & ~s_axi_bready);
            if (aw_take) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_reg  <= s_axi_wdata;
                w_strb0_reg <= s_axi_wstrb[0];
            end
            s_axi_bvalid <= wr_fire | (s_axi_bvalid & ~s_axi_bready);
            if (wr_fire) begin
                s_axi_bresp <= wa_ok ? RSQ_RESP_OK : RSQ_RESP_ERR;
            end
            if (wr_fire & wa_opt & w_strb0_reg) begin
                opt_reg <= w_data_reg[1:0];
            end
        end
    end

    // axi read channel
    always_ff @(posedge clock) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RSQ_RESP_OK;
        end else begin
            s_axi_rvalid  <= ar_take | (s_axi_rvalid & ~s_axi_rready);
            s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_ok ? RSQ_RESP_OK : RSQ_RESP_ERR;
            end
        end
    end

    // pin held low for the first cycles of the drive phase
    drive_len_a: assert property (
        @(posedge clock) disable iff (rst)
        $rose(state_reg == RSQ_DRIVE) |-> rst_pin_oe [*8])
        else $error("reset pin released early in drive phase");

    hold_release_a: assert property (
        @(posedge clock) disable iff (rst)
        (hold_done && !por_lvd) |=> (state_reg == RSQ_RUN && !rst_pin_oe))
        else $error("internal reset hold did not end after its count");

    por_pin_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg == RSQ_POR) |-> (rst_pin_oe && internal_reset && !cpu_clk_en))
        else $error("power-on phase without pin drive or with clocks");

    por_len_a: assert property (
        @(posedge clock) disable iff (rst)
        (por_done && !por_lvd) |=> (state_reg == RSQ_DRIVE && cnt_reg == 13'h0))
        else $error("long count did not hand over to pin drive");

    por_flag_a: assert property (
        @(posedge clock) disable iff (rst)
        por_s |=> (cause_reg == 8'h80))
        else $error("power-on flags wrong");

    fetch_only_a: assert property (
        @(posedge clock) disable iff (rst)
        $rose(cause_reg[RSQ_F_ADR]) |-> $past(opcode_fetch && fetch_unmapped))
        else $error("address flag set without an opcode fetch");

    svc_clear_a: assert property (
        @(posedge clock) disable iff (rst)
        svc |=> (cnt_reg[12:4] == 9'h0 && wd_cnt_reg == '0))
        else $error("service write did not clear counters");

    short_rec_a: assert property (
        @(posedge clock) disable iff (rst)
        (state_reg == RSQ_RECOV && opt_reg[RSQ_O_SHORT] && cnt_reg == 13'd31
         && !por_lvd && !pin_low) |=> cpu_clk_en)
        else $error("short stop recovery did not restart clocks");

    stop_bad_a: assert property (
        @(posedge clock) disable iff (rst)
        (running && stop_exec && !opt_reg[RSQ_O_STOPEN] && !por_lvd)
        |=> (state_reg == RSQ_DRIVE && cause_reg[RSQ_F_OPC]) ##1 rst_pin_oe)
        else $error("disabled stop did not cause opcode reset");

endmodule : rsq_internal_reset_sequencer

//--- testbench/rsq_pin_peer.sv
// reset pin partner: an outside peripheral that can hold the line low
// assumes an open-drain reset line with a pull-up
`timescale 1ns/1ns
module rsq_pin_peer (
    rst_pin_o,  // device drive value
    rst_pin_oe, // device drive enable
    pull_low,   // peripheral holds the line low
    pin_level   // resolved line level
);
    input  wire logic rst_pin_o;
    input  wire logic rst_pin_oe;
    input  wire logic pull_low;
    output logic      pin_level;
    assign pin_level = ((rst_pin_oe && !rst_pin_o) || pull_low) ? 1'b0 : 1'b1;
endmodule : rsq_pin_peer

//--- testbench/rsq_internal_reset_sequencer_tb.sv
// self-checking bench for the internal reset sequencer
// assumes the sequencer, its pin partner and an AXI4-Lite master made here
`timescale 1ns/1ns
module rsq_internal_reset_sequencer_tb;
    import rsq_pkg::*;
    typedef struct { logic [6:0] sel; int len; logic [7:0] cause; } rsq_row_s;
    logic        clock = 0, rst = 1, pull_low = 0, rst_pin_i, rst_pin_o, rst_pin_oe;
    logic        power_on_pulse = 0, low_voltage_detect = 0, wdog_req_async = 0;
    logic        hv_rst_pin = 0, hv_irq_pin = 0, monitor_mode = 0, break_state = 0;
    logic        bad_opcode = 0, stop_exec = 0, stop_wake = 0, opcode_fetch = 0;
    logic        fetch_unmapped = 0, internal_reset, clock_gen_output, cpu_clk_en;
    logic        wdog_disabled, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, rb;
    logic [12:0] c0;
    int          fail_count = 0, samples_checked = 0, cycles = 0, d, h, n;
    // rows: cause strobes, expected pin drive length, expected cause flags
    rsq_row_s    rows [7] = '{
        '{7'h01, RSQ_PIN_CYC, 8'h10}, '{7'h02, RSQ_PIN_CYC, 8'h10},
        '{7'h04, RSQ_PIN_CYC, 8'h08}, '{7'h08, RSQ_PIN_CYC, 8'h20},
        '{7'h20, 0, 8'h00}, '{7'h10, RSQ_POR_CYC + RSQ_PIN_CYC, 8'h02},
        '{7'h40, RSQ_POR_CYC + RSQ_PIN_CYC, 8'h80}};

    rsq_internal_reset_sequencer dut (.clock, .rst, .power_on_pulse, .low_voltage_detect,
        .wdog_req_async, .rst_pin_i, .rst_pin_o, .rst_pin_oe, .hv_rst_pin, .hv_irq_pin,
        .monitor_mode, .break_state, .bad_opcode, .stop_exec, .stop_wake, .opcode_fetch,
        .fetch_unmapped, .internal_reset, .clock_gen_output, .cpu_clk_en, .wdog_disabled,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    rsq_pin_peer peer (.rst_pin_o, .rst_pin_oe, .pull_low, .pin_level(rst_pin_i));

    // 50 MHz clock and hang limit
    always #10 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    // bus write: address and data offered together, each dropped when taken
    task automatic axw(input logic [7:0] a, input logic [31:0] dt);
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= dt;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rb = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw

    // bus read: data and response taken at the rvalid edge
    task automatic axr(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr

    // one-cycle strobe on the selected cause inputs
    task automatic fire(input logic [6:0] s);
        @(posedge clock);
        {power_on_pulse, low_voltage_detect, wdog_req_async} <= {s[6], s[4], s[3]};
        {opcode_fetch, stop_exec, bad_opcode} <= s[2:0];
        fetch_unmapped <= s[2] | s[5];
        @(posedge clock);
        {power_on_pulse, low_voltage_detect, wdog_req_async} <= 3'h0;
        {opcode_fetch, stop_exec, bad_opcode, fetch_unmapped} <= 4'h0;
    endtask : fire

    // cycles of pin drive, then of internal reset alone
    task automatic meas();
        d = 0;
        h = 0;
        n = 0;
        while (!rst_pin_oe && n < 60) begin
            @(posedge clock);
            n++;
        end
        while (rst_pin_oe) begin
            @(posedge clock);
            d++;
        end
        while (internal_reset && d > 0) begin
            @(posedge clock);
            h++;
        end
    endtask : meas

    // main sequence
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        meas();
        chk("por drive", RSQ_POR_CYC + RSQ_PIN_CYC, d);
        chk("por hold", RSQ_HOLD_CYC, h);
        chk("clock gen", 32'h1, 32'(clock_gen_output));
        axr(RSQ_OFS_CAUSE);
        chk("por cause", 32'(RSQ_CAUSE_RST), rd);
        chk("read resp", 32'(RSQ_RESP_OK), 32'(rr));
        axw(RSQ_OFS_CAUSE, 32'hff);
        chk("write resp", 32'(RSQ_RESP_OK), 32'(rb));
        foreach (rows[i]) begin
            fire(rows[i].sel);
            meas();
            chk("drive len", rows[i].len, d);
            chk("hold len", (rows[i].len > 0) ? RSQ_HOLD_CYC : 0, h);
            axr(RSQ_OFS_CAUSE);
            chk("cause", 32'(rows[i].cause), rd);
            if (i != 5) axw(RSQ_OFS_CAUSE, 32'hff);
        end
        axw(RSQ_OFS_OPT, 32'h3);
        fire(7'h02);
        repeat (4) @(posedge clock);
        chk("stop clocks", 32'h0, 32'(cpu_clk_en));
        axr(RSQ_OFS_STAT);
        chk("stop count", 32'h0, 32'(rd[12:0]));
        stop_wake <= 1'b1;
        @(posedge clock);
        stop_wake <= 1'b0;
        n = 0;
        while (!cpu_clk_en && n < 5000) begin
            @(posedge clock);
            n++;
        end
        chk("short recovery", 32'h1, 32'(n >= RSQ_SHORT_REC && n <= RSQ_SHORT_REC + 3));
        axr(RSQ_OFS_STAT);
        c0 = rd[12:0];
        pull_low <= 1'b1;
        repeat (8) @(posedge clock);
        chk("pin drive", 32'h0, 32'(rst_pin_oe));
        chk("pin value", 32'h0, 32'(rst_pin_o));
        chk("pin reset", 32'h1, 32'(internal_reset));
        pull_low <= 1'b0;
        repeat (4) @(posedge clock);
        axr(RSQ_OFS_STAT);
        chk("pin keeps count", 32'h1, 32'(rd[12:0] > c0));
        repeat (1100) @(posedge clock);
        axw(RSQ_OFS_SVC, 32'h5a);
        axr(RSQ_OFS_STAT);
        chk("service clear", 32'h1, 32'(rd[12:0] < 13'h40));
        axr(8'h40);
        chk("unmapped resp", 32'(RSQ_RESP_ERR), 32'(rr));
        axw(8'h40, 32'h0);
        chk("unmapped wresp", 32'(RSQ_RESP_ERR), 32'(rb));
        monitor_mode <= 1'b1;
        hv_irq_pin <= 1'b1;
        repeat (5) @(posedge clock);
        chk("wdog off", 32'h1, 32'(wdog_disabled));
        // long stop recovery, woken by an outside pin pulse
        axw(RSQ_OFS_OPT, 32'h1);
        fire(7'h02);
        pull_low <= 1'b1;
        @(posedge clock);
        pull_low <= 1'b0;
        n = 0;
        while (!cpu_clk_en && n < 5000) begin
            @(posedge clock);
            n++;
        end
        chk("long recovery", 32'h1, 32'(n >= RSQ_LONG_REC && n <= RSQ_LONG_REC + 6));
        // reset again in mid-run
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        chk("reset drive on", 32'h3, {30'h0, rst_pin_oe, internal_reset});
        rst <= 1'b0;
        @(posedge clock);
        meas();
        chk("reset drive", RSQ_POR_CYC + RSQ_PIN_CYC, d);
        axr(RSQ_OFS_OPT);
        chk("reset opt", 32'(RSQ_OPT_RST), rd);
        wrap_up();
    end
endmodule : rsq_internal_reset_sequencer_tb
